// >>> pif_pkg.sv
// Purpose: shared constants for the peripheral interrupt flag and enable bank
// Assumes: registers on classic Wishbone, one aligned 32-bit word each, data in bits 7:0
// Notes:   masks give implemented, software-writable and level-following bit positions
package pif_pkg;
    localparam int          PIF_DW          = 8;
    localparam int          PIF_AW          = 8;
    // register byte offsets
    localparam logic [7:0]  PIF_OFS_ENF     = 8'h00;
    localparam logic [7:0]  PIF_OFS_F1      = 8'h04;
    localparam logic [7:0]  PIF_OFS_F2      = 8'h08;
    localparam logic [7:0]  PIF_OFS_CTL     = 8'h0C;
    localparam logic [7:0]  PIF_OFS_ISTAT   = 8'h10;
    localparam logic [7:0]  PIF_OFS_ICLR    = 8'h14;
    localparam logic [7:0]  PIF_OFS_IEN     = 8'h18;
    // reset value of every implemented bit
    localparam logic [7:0]  PIF_RST_VAL     = 8'h00;
    // fourth enable register fields
    localparam int          PIF_ENF_ASYNC2_RX   = 5;
    localparam int          PIF_ENF_ASYNC2_TX   = 4;
    localparam int          PIF_ENF_SYNC2_COLL  = 1;
    localparam int          PIF_ENF_SYNC2_EVT   = 0;
    localparam logic [7:0]  PIF_ENF_IMPL    = 8'h33;
    // first flag register fields
    localparam int          PIF_F1_TIMER1_GATE  = 7;
    localparam int          PIF_F1_CONV_DONE    = 6;
    localparam int          PIF_F1_ASYNC1_RX    = 5;
    localparam int          PIF_F1_ASYNC1_TX    = 4;
    localparam int          PIF_F1_SYNC1_EVT    = 3;
    localparam int          PIF_F1_CAPCMP1      = 2;
    localparam int          PIF_F1_TIMER2_MATCH = 1;
    localparam int          PIF_F1_TIMER1_OVF   = 0;
    localparam logic [7:0]  PIF_F1_IMPL     = 8'hFF;
    localparam logic [7:0]  PIF_F1_WR       = 8'hCF;
    localparam logic [7:0]  PIF_F1_LEVEL    = 8'h30;
    // second flag register fields
    localparam int          PIF_F2_OSC_FAIL     = 7;
    localparam int          PIF_F2_COMP_TWO     = 6;
    localparam int          PIF_F2_COMP_ONE     = 5;
    localparam int          PIF_F2_EEPROM_DONE  = 4;
    localparam int          PIF_F2_SYNC1_COLL   = 3;
    localparam int          PIF_F2_LCD          = 2;
    localparam int          PIF_F2_CAPCMP2      = 0;
    localparam logic [7:0]  PIF_F2_IMPL     = 8'hFD;
    localparam logic [7:0]  PIF_F2_WR       = 8'hFD;
    localparam logic [7:0]  PIF_F2_LEVEL    = 8'h00;
    // main control register fields
    localparam int          PIF_CTL_GLOBAL_EN   = 7;
    localparam int          PIF_CTL_PERIPH_GATE = 6;
    localparam logic [7:0]  PIF_CTL_IMPL    = 8'hC0;
    // block interrupt status events
    localparam int          PIF_EVT_N           = 2;
    localparam int          PIF_EVT_REQ_RISE    = 0;
    localparam int          PIF_EVT_BUS_ERR     = 1;
endpackage

// >>> pif_flag_bank.sv
// Purpose: one 8-bit bank of peripheral request flags
// Assumes: set pulses and levels come from logic on the same clock
// Notes:   a hardware set in the same cycle as a software write of 0 wins
`timescale 1ns/1ps
module pif_flag_bank
    import pif_pkg::*;
#(
    parameter int         W          = 8,
    parameter logic [7:0] IMPL_MASK  = 8'hFF,
    parameter logic [7:0] WR_MASK    = 8'hFF,
    parameter logic [7:0] LEVEL_MASK = 8'h00
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // event sources
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] level_i,
    // software write port
    input  wire logic         wr_i,
    input  wire logic [W-1:0] wdata_i,
    // flag state
    output logic      [W-1:0] flags_o
);
    for (genvar b = 0; b < W; b++) begin : g_bit
        if (!IMPL_MASK[b]) begin : g_unimpl
            assign flags_o[b] = 1'b0;
        end else if (LEVEL_MASK[b]) begin : g_level
            logic flag_r;
            // read-only flag mirrors its source status
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    flag_r <= PIF_RST_VAL[0];
                end else begin
                    flag_r <= level_i[b];
                end
            end
            assign flags_o[b] = flag_r;
        end else begin : g_sticky
            logic flag_r;
            logic flag_nxt;
            always_comb begin
                flag_nxt = flag_r;
                if (wr_i && WR_MASK[b]) begin
                    flag_nxt = wdata_i[b];
                end
                if (set_i[b]) begin
                    flag_nxt = 1'b1;
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    flag_r <= PIF_RST_VAL[0];
                end else begin
                    flag_r <= flag_nxt;
                end
            end
            assign flags_o[b] = flag_r;
        end
    end
endmodule

// >>> pif_irq_status.sv
// Purpose: sticky event status, enable and clear for the block interrupt line
// Assumes: event pulses on the same clock
// Notes:   set wins over a clear written in the same cycle
`timescale 1ns/1ps
module pif_irq_status
    import pif_pkg::*;
#(
    parameter int N = PIF_EVT_N
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // events
    input  wire logic [N-1:0] evt_i,
    // software access
    input  wire logic         clr_wr_i,
    input  wire logic         en_wr_i,
    input  wire logic [N-1:0] wdata_i,
    // state
    output logic      [N-1:0] status_o,
    output logic      [N-1:0] enable_o,
    output logic              irq_o
);
    logic [N-1:0] status_r;
    logic [N-1:0] enable_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~(clr_wr_i ? wdata_i : '0)) | evt_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_r <= '0;
        end else if (en_wr_i) begin
            enable_r <= wdata_i;
        end
    end

    assign status_o = status_r;
    assign enable_o = enable_r;
    assign irq_o    = |(status_r & enable_r);
endmodule

// >>> pif_bank_top.sv
// Overview of operation
// - a request flag is set by its event whatever its own enable or the global enables hold.
// - the fourth enable register holds async2 rx, async2 tx, sync2 collision, sync2 event.
// - unimplemented bits read zero and ignore writes.
// - an implemented enable bit at 1 enables its interrupt and at 0 disables it.
// - an implemented flag reads 1 while its interrupt is pending and 0 otherwise.
// - the first flag register holds the eight flags in their fixed bit order.
// - async1 rx and tx flags are read-only, the other six first-register flags read-write.
// - the second flag register holds seven flags in their fixed order, bit 1 empty.
// - every implemented enable and flag bit resets to zero on any reset.
// - no peripheral request reaches the core unless the peripheral gate enable is set.
//
// Purpose: peripheral interrupt flag and enable bank behind a Wishbone slave
// Assumes: event sources and the enables of banks one and two come from same-clock logic
// Notes:   ack follows one cycle after the request; unmapped words answer zero
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module pif_bank_top
    import pif_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [PIF_AW-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // peripheral event sources
    input  wire logic [PIF_DW-1:0] flags_one_set_i,
    input  wire logic              async1_rx_flag_i,
    input  wire logic              async1_tx_flag_i,
    input  wire logic [PIF_DW-1:0] flags_two_set_i,
    input  wire logic [PIF_DW-1:0] flags_four_i,
    // enables held elsewhere for banks one and two
    input  wire logic [PIF_DW-1:0] enable_one_i,
    input  wire logic [PIF_DW-1:0] enable_two_i,
    // outputs
    output logic      [PIF_DW-1:0] periph_irq_enable_four_o,
    output logic                   periph_irq_o,
    output logic                   irq_o
);
    logic              req_acc;
    logic              wr_acc;
    logic              ack_r;
    logic [31:0]       dat_r;
    logic              lane0;
    logic              sel_enf;
    logic              sel_f1;
    logic              sel_f2;
    logic              sel_ctl;
    logic              sel_istat;
    logic              sel_iclr;
    logic              sel_ien;
    logic              mapped;
    logic [PIF_DW-1:0] wdata;
    logic [PIF_DW-1:0] enable_four_r;
    logic [PIF_DW-1:0] ctl_r;
    logic [PIF_DW-1:0] flags_one;
    logic [PIF_DW-1:0] flags_two;
    logic [PIF_DW-1:0] flags_one_lvl;
    logic              global_irq_en;
    logic              periph_irq_gate_en;
    logic              any_pending;
    logic              periph_req;
    logic              periph_req_r;
    logic [PIF_EVT_N-1:0] evt;
    logic [PIF_EVT_N-1:0] istat;
    logic [PIF_EVT_N-1:0] ien;
    logic [PIF_DW-1:0] rd_byte;

    // bus decode; a request is taken once, in the cycle before ack
    assign req_acc   = wb_cyc_i && wb_stb_i && !ack_r;
    assign lane0     = wb_sel_i[0];
    assign wr_acc    = req_acc && wb_we_i && lane0;
    assign wdata     = wb_dat_i[PIF_DW-1:0];
    assign sel_enf   = (wb_adr_i == PIF_OFS_ENF);
    assign sel_f1    = (wb_adr_i == PIF_OFS_F1);
    assign sel_f2    = (wb_adr_i == PIF_OFS_F2);
    assign sel_ctl   = (wb_adr_i == PIF_OFS_CTL);
    assign sel_istat = (wb_adr_i == PIF_OFS_ISTAT);
    assign sel_iclr  = (wb_adr_i == PIF_OFS_ICLR);
    assign sel_ien   = (wb_adr_i == PIF_OFS_IEN);
    assign mapped    = sel_enf | sel_f1 | sel_f2 | sel_ctl | sel_istat | sel_iclr | sel_ien;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req_acc;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        case (1'b1)
            sel_enf:   rd_byte = enable_four_r;
            sel_f1:    rd_byte = flags_one;
            sel_f2:    rd_byte = flags_two;
            sel_ctl:   rd_byte = ctl_r;
            sel_istat: rd_byte = {{(PIF_DW-PIF_EVT_N){1'b0}}, istat};
            sel_ien:   rd_byte = {{(PIF_DW-PIF_EVT_N){1'b0}}, ien};
            default:   rd_byte = 8'h00;
        endcase
    end

    // read data is captured with the request, so it stands with ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req_acc) begin
            dat_r <= {24'h00_0000, rd_byte};
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // fourth enable register; unimplemented positions are never stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_four_r <= PIF_RST_VAL;
        end else if (wr_acc && sel_enf) begin
            enable_four_r <= wdata & PIF_ENF_IMPL;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_r <= PIF_RST_VAL;
        end else if (wr_acc && sel_ctl) begin
            ctl_r <= wdata & PIF_CTL_IMPL;
        end
    end

    assign global_irq_en            = ctl_r[PIF_CTL_GLOBAL_EN];
    assign periph_irq_gate_en       = ctl_r[PIF_CTL_PERIPH_GATE];
    assign periph_irq_enable_four_o = enable_four_r;

    // async1 rx/tx flags follow their source and ignore writes
    always_comb begin
        flags_one_lvl                   = 8'h00;
        flags_one_lvl[PIF_F1_ASYNC1_RX] = async1_rx_flag_i;
        flags_one_lvl[PIF_F1_ASYNC1_TX] = async1_tx_flag_i;
    end

    // flags set regardless of any enable state
    pif_flag_bank #(
        .W          (PIF_DW),
        .IMPL_MASK  (PIF_F1_IMPL),
        .WR_MASK    (PIF_F1_WR),
        .LEVEL_MASK (PIF_F1_LEVEL)
    ) u_flags_one (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (flags_one_set_i & ~PIF_F1_LEVEL),
        .level_i (flags_one_lvl),
        .wr_i    (wr_acc && sel_f1),
        .wdata_i (wdata),
        .flags_o (flags_one)
    );

    pif_flag_bank #(
        .W          (PIF_DW),
        .IMPL_MASK  (PIF_F2_IMPL),
        .WR_MASK    (PIF_F2_WR),
        .LEVEL_MASK (PIF_F2_LEVEL)
    ) u_flags_two (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (flags_two_set_i & PIF_F2_IMPL),
        .level_i (8'h00),
        .wr_i    (wr_acc && sel_f2),
        .wdata_i (wdata),
        .flags_o (flags_two)
    );

    // request toward the core
    assign any_pending = |(flags_one & enable_one_i)
                       | |(flags_two & enable_two_i)
                       | |(flags_four_i & enable_four_r);
    assign periph_req  = any_pending && periph_irq_gate_en && global_irq_en;
    assign periph_irq_o = periph_req;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            periph_req_r <= 1'b0;
        end else begin
            periph_req_r <= periph_req;
        end
    end

    always_comb begin
        evt                   = '0;
        evt[PIF_EVT_REQ_RISE] = periph_req && !periph_req_r;
        evt[PIF_EVT_BUS_ERR]  = req_acc && !mapped;
    end

    pif_irq_status #(
        .N (PIF_EVT_N)
    ) u_irq_status (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .evt_i    (evt),
        .clr_wr_i (wr_acc && sel_iclr),
        .en_wr_i  (wr_acc && sel_ien),
        .wdata_i  (wdata[PIF_EVT_N-1:0]),
        .status_o (istat),
        .enable_o (ien),
        .irq_o    (irq_o)
    );

    chk_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_one_set_i[PIF_F1_TIMER1_OVF] && enable_one_i[PIF_F1_TIMER1_OVF] == 1'b0
        |=> flags_one[PIF_F1_TIMER1_OVF])
        else $error("flag not set by its event while disabled");

    chk_enf_unimpl: assert property (@(posedge clk_i) disable iff (rst_i)
        (enable_four_r & ~PIF_ENF_IMPL) == 8'h00 && flags_two[1] == 1'b0)
        else $error("unimplemented bit reads one");

    chk_enf_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_acc && sel_enf |=> enable_four_r == ($past(wdata) & PIF_ENF_IMPL))
        else $error("fourth enable write not stored");

    chk_async_ro: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> flags_one[5:4] == $past({async1_rx_flag_i, async1_tx_flag_i}))
        else $error("read-only flag diverges from its source");

    chk_f2_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_acc && sel_f2 && flags_two_set_i == 8'h00
        |=> flags_two == ($past(wdata) & PIF_F2_WR))
        else $error("second flag write not stored");

    chk_reset_zero: assert property (@(posedge clk_i)
        !rst_i && $past(rst_i) |-> enable_four_r == 8'h00 && flags_two == 8'h00
        && (flags_one & ~PIF_F1_LEVEL) == 8'h00)
        else $error("register not zero after reset");

    chk_gate_needed: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctl_r[PIF_CTL_PERIPH_GATE] |-> !periph_irq_o)
        else $error("request passed with peripheral gate clear");

    chk_req_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_four_i[PIF_ENF_SYNC2_EVT] && enable_four_r[PIF_ENF_SYNC2_EVT]
        && ctl_r[PIF_CTL_GLOBAL_EN] && ctl_r[PIF_CTL_PERIPH_GATE] |-> periph_irq_o)
        else $error("enabled pending flag raised no request");

    chk_en_disable: assert property (@(posedge clk_i) disable iff (rst_i)
        enable_one_i == 8'h00 && enable_two_i == 8'h00 && enable_four_r == 8'h00
        |-> !periph_irq_o)
        else $error("request with every enable clear");

    chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle after request");

    chk_f1_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_acc && sel_f1 && flags_one_set_i == 8'h00
        |=> (flags_one & PIF_F1_WR) == ($past(wdata) & PIF_F1_WR))
        else $error("first flag write not stored");

    chk_f2_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_two_set_i[PIF_F2_CAPCMP2] && enable_two_i[PIF_F2_CAPCMP2] == 1'b0
        |=> flags_two[PIF_F2_CAPCMP2])
        else $error("second bank flag not set while disabled");

    chk_global_needed: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctl_r[PIF_CTL_GLOBAL_EN] |-> !periph_irq_o)
        else $error("request passed with global enable clear");

    chk_req_two: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_two[PIF_F2_CAPCMP2] && enable_two_i[PIF_F2_CAPCMP2]
        && ctl_r[PIF_CTL_GLOBAL_EN] && ctl_r[PIF_CTL_PERIPH_GATE] |-> periph_irq_o)
        else $error("enabled second bank flag raised no request");

    chk_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
        req_acc && !wb_we_i && sel_f1 |=> wb_dat_o == {24'h00_0000, $past(flags_one)})
        else $error("first flag read data wrong");

    chk_ctl_unimpl: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctl_r & ~PIF_CTL_IMPL) == 8'h00)
        else $error("control register unused bit set");

    chk_unmapped_err: assert property (@(posedge clk_i) disable iff (rst_i)
        req_acc && !mapped |=> istat[PIF_EVT_BUS_ERR])
        else $error("unmapped access not latched");

    chk_rise_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        periph_req && !periph_req_r |=> istat[PIF_EVT_REQ_RISE])
        else $error("request rise not latched");

    chk_clr_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        req_acc && !wb_we_i && sel_iclr |=> wb_dat_o == 32'h0000_0000)
        else $error("clear register read not zero");

    chk_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_cyc_i |=> !wb_ack_o)
        else $error("ack without a cycle");
endmodule

// >>> pif_src_model.sv
// Purpose: event source model for the flag bank: set pulses and status levels
// Assumes: driven from the bench through its tasks, changes land just after a rising edge
// Notes:   pulses last exactly one cycle, as a real same-clock peripheral would give them
`timescale 1ns/1ps
module pif_src_model
    import pif_pkg::*;
(
    // clock
    input  wire logic              clk_i,
    // event outputs
    output logic      [PIF_DW-1:0] set_one_o,
    output logic      [PIF_DW-1:0] set_two_o,
    output logic                   rx_lvl_o,
    output logic                   tx_lvl_o,
    output logic      [PIF_DW-1:0] four_o
);
    initial begin
        set_one_o = 8'h00;
        set_two_o = 8'h00;
        rx_lvl_o  = 1'b0;
        tx_lvl_o  = 1'b0;
        four_o    = 8'h00;
    end

    // events fire whatever the enables hold
    task automatic pulse(input logic [7:0] m1, input logic [7:0] m2);
        @(posedge clk_i);
        set_one_o <= m1;
        set_two_o <= m2;
        @(posedge clk_i);
        set_one_o <= 8'h00;
        set_two_o <= 8'h00;
    endtask

    task automatic levels(input logic rx, input logic tx, input logic [7:0] f4);
        @(posedge clk_i);
        rx_lvl_o <= rx;
        tx_lvl_o <= tx;
        four_o   <= f4;
    endtask
endmodule

// >>> tb_top.sv
// Purpose: register-level regression of the peripheral flag and enable bank
// Assumes: one-cycle Wishbone ack, offsets and masks from the package
// Notes:   expected values come from the bit layouts, never from the design
`timescale 1ns/1ps
module tb_top
    import pif_pkg::*;
;
    logic              clk_i  = 1'b0;
    logic              rst_i  = 1'b1;
    logic              cyc    = 1'b0;
    logic              stb    = 1'b0;
    logic              we     = 1'b0;
    logic [7:0]        adr    = 8'h00;
    logic [3:0]        sel    = 4'h0;
    logic [31:0]       dat    = 32'h0;
    logic [7:0]        en_one = 8'h00;
    logic [7:0]        en_two = 8'h00;
    logic [31:0]       rd;
    logic [31:0]       dat_o;
    logic              ack;
    logic [7:0]        s1, s2, f4, enf;
    logic              rx, tx, pirq, irq;
    int                err_count  = 0;
    int                num_checks = 0;

    always #20 clk_i = ~clk_i;

    pif_src_model i_src (.clk_i(clk_i), .set_one_o(s1), .set_two_o(s2),
                         .rx_lvl_o(rx), .tx_lvl_o(tx), .four_o(f4));

    pif_bank_top i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .flags_one_set_i(s1), .async1_rx_flag_i(rx), .async1_tx_flag_i(tx),
        .flags_two_set_i(s2), .flags_four_i(f4), .enable_one_i(en_one),
        .enable_two_i(en_two), .periph_irq_enable_four_o(enf), .periph_irq_o(pirq),
        .irq_o(irq));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one classic cycle; the request stands until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100) begin
            chk("ack", 32'h0, 32'h1);
            wrap_up();
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk(nm, rd, {24'h0, exp});
    endtask

    task automatic settle;
        @(posedge clk_i);
        #1;
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        wrap_up();
    end

    initial begin
        logic [7:0] m;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("enf rst", PIF_OFS_ENF, 8'h00);
        rdchk("f1 rst", PIF_OFS_F1, 8'h00);
        rdchk("f2 rst", PIF_OFS_F2, 8'h00);
        wb(1'b1, PIF_OFS_ENF, 8'hFF);
        rdchk("enf bits", PIF_OFS_ENF, 8'h33);
        chk("enf port", {24'h0, enf}, 32'h33);
        wb(1'b1, PIF_OFS_ENF, 8'h00);
        wb(1'b1, PIF_OFS_F1, 8'hFF);
        rdchk("f1 sw", PIF_OFS_F1, 8'hCF);
        wb(1'b1, PIF_OFS_F2, 8'hFF);
        rdchk("f2 sw", PIF_OFS_F2, 8'hFD);
        wb(1'b1, PIF_OFS_F1, 8'h00);
        wb(1'b1, PIF_OFS_F2, 8'h00);
        rdchk("f1 clr", PIF_OFS_F1, 8'h00);
        // one event at a time, all enables off, so each lands on its own bit
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            i_src.pulse(m, m);
            rdchk("f1 evt", PIF_OFS_F1, m & 8'hCF);
            rdchk("f2 evt", PIF_OFS_F2, m & 8'hFD);
            wb(1'b1, PIF_OFS_F1, 8'h00);
            wb(1'b1, PIF_OFS_F2, 8'h00);
        end
        i_src.levels(1'b1, 1'b0, 8'h00);
        wb(1'b1, PIF_OFS_F1, 8'h00);
        rdchk("f1 rx", PIF_OFS_F1, 8'h20);
        i_src.levels(1'b0, 1'b1, 8'h00);
        settle();
        rdchk("f1 tx", PIF_OFS_F1, 8'h10);
        i_src.levels(1'b0, 1'b0, 8'h00);
        wb(1'b1, PIF_OFS_F1, 8'h00); // flag cleared before its enable
        @(posedge clk_i);
        en_one <= 8'h01;
        i_src.pulse(8'h01, 8'h00);
        settle();
        chk("req gates off", {31'h0, pirq}, 32'h0);
        wb(1'b1, PIF_OFS_CTL, 8'h40);
        settle();
        chk("req no global", {31'h0, pirq}, 32'h0);
        wb(1'b1, PIF_OFS_CTL, 8'hC0);
        settle();
        chk("req on", {31'h0, pirq}, 32'h1);
        rdchk("ctl", PIF_OFS_CTL, 8'hC0);
        wb(1'b1, PIF_OFS_CTL, 8'h80);
        settle();
        chk("req no gate", {31'h0, pirq}, 32'h0);
        wb(1'b1, PIF_OFS_CTL, 8'hC0);
        en_one <= 8'h00;
        settle();
        chk("req en off", {31'h0, pirq}, 32'h0);
        i_src.levels(1'b0, 1'b0, 8'h03);
        wb(1'b1, PIF_OFS_ENF, 8'h01);
        settle();
        chk("req four", {31'h0, pirq}, 32'h1);
        wb(1'b1, PIF_OFS_ENF, 8'h00);
        settle();
        chk("req four off", {31'h0, pirq}, 32'h0);
        // second bank: flag is clear when its enable goes up
        @(posedge clk_i);
        en_two <= 8'h01;
        i_src.pulse(8'h00, 8'h01);
        settle();
        chk("req two", {31'h0, pirq}, 32'h1);
        @(posedge clk_i);
        en_two <= 8'h00;
        wb(1'b1, PIF_OFS_F2, 8'h00);
        // block interrupt: request rise is latched, unmapped access is latched
        wb(1'b1, PIF_OFS_IEN, 8'h03);
        rdchk("unmapped", 8'h1C, 8'h00);
        rdchk("istat", PIF_OFS_ISTAT, 8'h03);
        settle();
        chk("irq on", {31'h0, irq}, 32'h1);
        wb(1'b1, PIF_OFS_ICLR, 8'h01);
        rdchk("istat clr", PIF_OFS_ISTAT, 8'h02);
        wb(1'b1, PIF_OFS_IEN, 8'h01);
        settle();
        chk("irq masked", {31'h0, irq}, 32'h0);
        wb(1'b1, PIF_OFS_ICLR, 8'h02);
        rdchk("istat empty", PIF_OFS_ISTAT, 8'h00);
        rdchk("iclr rd", PIF_OFS_ICLR, 8'h00);
        // reset in mid-run with state loaded
        wb(1'b1, PIF_OFS_ENF, 8'h33);
        i_src.pulse(8'hFF, 8'hFF);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk("enf rst2", PIF_OFS_ENF, 8'h00);
        rdchk("f1 rst2", PIF_OFS_F1, 8'h00);
        rdchk("f2 rst2", PIF_OFS_F2, 8'h00);
        wrap_up();
    end
endmodule
